// ==== rse_exec.sv ====
module rse_exec (
  input wire logic core_clk, // 50 MHz core clock, quarter-phase rate
  input wire logic rst_n, // Sync reset, active low
  input wire logic [15:0] instr_word, // Fetched instruction
  input wire logic instr_valid, // Word offered at cycle start
  input wire logic irq_high_level, // Serviced interrupt was high priority
  input wire logic [7:0] shadow_accumulator, // Shadow copy of accumulator
  input wire logic [7:0] shadow_status, // Shadow copy of status
  input wire logic [7:0] shadow_bank_select, // Shadow copy of bank select
  input wire logic [7:0] pc_latch_high_byte, // Latch value written by core
  input wire logic [7:0] pc_latch_upper_byte, // Latch value written by core
  input wire logic latch_we, // Core writes both latches
  output logic instr_ready, // Takes a word this cycle
  output logic [rse_pkg::PC_W-1:0] pc_out, // Program counter
  output logic [rse_pkg::PC_W-1:0] stack_top_entry, // Top of return stack
  output logic [rse_pkg::STK_PTR_W:0] stack_level, // Entries in use
  output logic [7:0] accumulator, // Working accumulator
  output logic [7:0] status_out, // Working status
  output logic [7:0] bank_select_register, // Working bank select
  output logic [7:0] latch_high_out, // High latch byte
  output logic [7:0] latch_upper_out, // Upper latch byte
  output logic high_priority_global_irq_enable, // High enable bit
  output logic low_priority_global_irq_enable, // Low enable bit
  output logic master_clear_reset // Software reset pulse
);
  ////////////////////////////////////////////////////////////////////
  rse_pkg::rse_state_t state_reg, state_next;
  logic [1:0] q_reg, q_next;
  logic [15:0] ir_reg, ir_next;
  logic [rse_pkg::PC_W-1:0] pc_reg, pc_next;
  logic [rse_pkg::STK_PTR_W:0] sp_reg, sp_next;
  logic [7:0] acc_reg, acc_next, st_reg, st_next, bank_reg, bank_next;
  logic [7:0] lh_reg, lh_next, lu_reg, lu_next;
  logic en_hi_reg, en_hi_next, en_lo_reg, en_lo_next, swrst_reg, swrst_next;
  logic stk_we;
  logic [rse_pkg::STK_PTR_W-1:0] stk_waddr, stk_raddr;
  logic [rse_pkg::PC_W-1:0] stk_wdata, stk_rdata, pc_plus2, rel_off;
  logic is_pop, is_push, is_relcall, is_swrst, is_iret, is_ret, is_litret, is_idle;
  logic q_end;

  ////////////////////////////////////////////////////////////////////
  assign pc_plus2 = pc_reg + rse_pkg::PC_STEP;
  assign rel_off = {{(rse_pkg::PC_W - 12){ir_reg[10]}}, ir_reg[10:0], 1'b0};
  assign is_pop = ir_reg == rse_pkg::OP_POP;
  assign is_push = ir_reg == rse_pkg::OP_PUSH;
  assign is_relcall = ir_reg[15:11] == rse_pkg::OP_RELCALL_HI;
  assign is_swrst = ir_reg == rse_pkg::OP_SWRESET;
  assign is_iret = ir_reg[15:1] == rse_pkg::OP_IRET_HI;
  assign is_ret = ir_reg[15:1] == rse_pkg::OP_RET_HI;
  assign is_litret = ir_reg[15:8] == rse_pkg::OP_LITRET_HI;
  assign is_idle = ir_reg == rse_pkg::OP_IDLE || ir_reg[15:12] == rse_pkg::OP_IDLE_HI;
  assign q_end = q_reg == rse_pkg::Q_LAST;
  assign instr_ready = q_end && !(state_reg == rse_pkg::RSE_EXEC && (is_relcall || is_iret
                       || is_ret || is_litret));
  assign stk_raddr = sp_next[rse_pkg::STK_PTR_W-1:0] - 3'h1;

  rse_stack_mem u_stack (
    .core_clk(core_clk),
    .we(stk_we),
    .waddr(stk_waddr),
    .wdata(stk_wdata),
    .raddr(stk_raddr),
    .rdata(stk_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    q_next = q_reg + 2'h1;
    ir_next = ir_reg;
    pc_next = pc_reg;
    sp_next = sp_reg;
    acc_next = acc_reg;
    st_next = st_reg;
    bank_next = bank_reg;
    lh_next = lh_reg;
    lu_next = lu_reg;
    en_hi_next = en_hi_reg;
    en_lo_next = en_lo_reg;
    swrst_next = 1'b0;
    stk_we = 1'b0;
    stk_waddr = sp_reg[rse_pkg::STK_PTR_W-1:0];
    stk_wdata = pc_plus2;
    if (latch_we) begin
      lh_next = pc_latch_high_byte;
      lu_next = pc_latch_upper_byte;
    end
    if (q_end) begin
      if (state_reg == rse_pkg::RSE_IDLE2) begin
        state_next = rse_pkg::RSE_EXEC;
        ir_next = instr_valid ? instr_word : rse_pkg::OP_IDLE;
      end else begin
        ir_next = instr_valid ? instr_word : rse_pkg::OP_IDLE;
        pc_next = pc_plus2;
        if (is_pop) begin
          sp_next = sp_reg - 4'h1;
        end else if (is_push) begin
          stk_we = 1'b1;
          sp_next = sp_reg + 4'h1;
        end else if (is_relcall) begin
          stk_we = 1'b1;
          sp_next = sp_reg + 4'h1;
          pc_next = pc_plus2 + rel_off;
          state_next = rse_pkg::RSE_IDLE2;
          ir_next = rse_pkg::OP_IDLE;
        end else if (is_swrst) begin
          swrst_next = 1'b1;
          pc_next = rse_pkg::PC_RESET;
          sp_next = '0;
          acc_next = rse_pkg::REG_RESET;
          st_next = rse_pkg::REG_RESET;
          bank_next = rse_pkg::REG_RESET;
          lh_next = rse_pkg::REG_RESET;
          lu_next = rse_pkg::REG_RESET;
          en_hi_next = 1'b0;
          en_lo_next = 1'b0;
          ir_next = rse_pkg::OP_IDLE;
        end else if (is_iret || is_ret || is_litret) begin
          pc_next = stack_top_entry;
          sp_next = sp_reg - 4'h1;
          state_next = rse_pkg::RSE_IDLE2;
          ir_next = rse_pkg::OP_IDLE;
          if (is_iret && irq_high_level) begin
            en_hi_next = 1'b1;
          end else if (is_iret) begin
            en_lo_next = 1'b1;
          end
          if (is_litret) begin
            acc_next = ir_reg[7:0];
          end else if (ir_reg[0]) begin
            acc_next = shadow_accumulator;
            st_next = shadow_status;
            bank_next = shadow_bank_select;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= rse_pkg::RSE_EXEC;
      q_reg <= rse_pkg::Q_FIRST;
      ir_reg <= rse_pkg::OP_IDLE;
      pc_reg <= rse_pkg::PC_RESET;
      sp_reg <= '0;
      acc_reg <= rse_pkg::REG_RESET;
      st_reg <= rse_pkg::REG_RESET;
      bank_reg <= rse_pkg::REG_RESET;
      lh_reg <= rse_pkg::REG_RESET;
      lu_reg <= rse_pkg::REG_RESET;
      en_hi_reg <= 1'b0;
      en_lo_reg <= 1'b0;
      swrst_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      q_reg <= q_next;
      ir_reg <= ir_next;
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      acc_reg <= acc_next;
      st_reg <= st_next;
      bank_reg <= bank_next;
      lh_reg <= lh_next;
      lu_reg <= lu_next;
      en_hi_reg <= en_hi_next;
      en_lo_reg <= en_lo_next;
      swrst_reg <= swrst_next;
    end
  end

  assign stack_top_entry = stk_rdata;
  assign pc_out = pc_reg;
  assign stack_level = sp_reg;
  assign accumulator = acc_reg;
  assign status_out = st_reg;
  assign bank_select_register = bank_reg;
  assign latch_high_out = lh_reg;
  assign latch_upper_out = lu_reg;
  assign high_priority_global_irq_enable = en_hi_reg;
  assign low_priority_global_irq_enable = en_lo_reg;
  assign master_clear_reset = swrst_reg;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  push_depth_a: assert property (q_end && state_reg == rse_pkg::RSE_EXEC && is_push
    |=> sp_reg == $past(sp_reg) + 4'h1 && stack_top_entry == $past(pc_plus2))
    else $error("push did not stack pc+2");
  pop_depth_a: assert property (q_end && state_reg == rse_pkg::RSE_EXEC && is_pop
    |=> sp_reg == $past(sp_reg) - 4'h1) else $error("pop did not drop level");
  relcall_target_a: assert property (q_end && state_reg == rse_pkg::RSE_EXEC && is_relcall
    |=> pc_reg == $past(pc_plus2 + rel_off) ##0 state_reg == rse_pkg::RSE_IDLE2 [*4])
    else $error("relative call target wrong");
  swreset_a: assert property (q_end && state_reg == rse_pkg::RSE_EXEC && is_swrst
    |=> master_clear_reset && pc_reg == rse_pkg::PC_RESET && acc_reg == rse_pkg::REG_RESET)
    else $error("software reset incomplete");
  iret_enable_a: assert property (q_end && state_reg == rse_pkg::RSE_EXEC && is_iret
    |=> (en_hi_reg || en_lo_reg) && pc_reg == $past(stack_top_entry))
    else $error("interrupt return enable missing");
  shadow_keep_a: assert property (q_end && state_reg == rse_pkg::RSE_EXEC && is_ret
    && !ir_reg[0] |=> $stable(st_reg) && $stable(bank_reg)) else $error("shadow restored wrongly");
  latch_keep_a: assert property (q_end && (is_ret || is_iret) && !latch_we
    |=> $stable(lh_reg) && $stable(lu_reg)) else $error("latch changed on return");
  litret_acc_a: assert property (q_end && state_reg == rse_pkg::RSE_EXEC && is_litret
    |=> acc_reg == $past(ir_reg[7:0]) ##4 state_reg == rse_pkg::RSE_EXEC)
    else $error("literal return wrong");
  idle_keep_a: assert property (q_end && state_reg == rse_pkg::RSE_EXEC && is_idle
    |=> $stable(sp_reg) && $stable(acc_reg) && pc_reg == $past(pc_plus2))
    else $error("idle changed state");

  relcall_c: cover property (q_end && is_relcall && state_reg == rse_pkg::RSE_EXEC);
  iret_shadow_c: cover property (q_end && is_iret && ir_reg[0]);
  litret_c: cover property (q_end && is_litret);
  push_pop_c: cover property (q_end && is_push ##4 q_end && is_pop);
endmodule // rse_exec

// ==== rse_fetch_model.sv ====
module rse_fetch_model (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic instr_ready, // Word taken at this edge
  output logic [15:0] instr_word, // Offered word
  output logic instr_valid // Offered word is real
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] prog [16];
  int taken = 0;
  time take_t [16];
  initial instr_word = 16'h0000;
  initial instr_valid = 1'b0;
  // Word held until taken, then the next one offered
  always @(posedge core_clk) begin
    if (!rst_n) taken <= 0;
    else if (instr_ready === 1'b1 && taken < 15) begin
      take_t[taken] <= $time;
      taken <= taken + 1;
    end
    #1;
    instr_word <= prog[taken];
    instr_valid <= rst_n;
  end
endmodule // rse_fetch_model

// ==== rse_pkg.sv ====
package rse_pkg;
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 8;
  localparam int STK_PTR_W = 3;
  localparam logic [15:0] OP_IDLE = 16'h0000;
  localparam logic [15:0] OP_POP = 16'h0006;
  localparam logic [15:0] OP_PUSH = 16'h0005;
  localparam logic [15:0] OP_SWRESET = 16'h00FF;
  localparam logic [14:0] OP_IRET_HI = 15'h0008;
  localparam logic [14:0] OP_RET_HI = 15'h0009;
  localparam logic [7:0] OP_LITRET_HI = 8'h0C;
  localparam logic [4:0] OP_RELCALL_HI = 5'h1B;
  localparam logic [3:0] OP_IDLE_HI = 4'hF;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] Q_FIRST = 2'h0;
  typedef enum logic [1:0] {
    RSE_EXEC = 2'b00,
    RSE_IDLE2 = 2'b01
  } rse_state_t;
endpackage

// ==== rse_stack_mem.sv ====
module rse_stack_mem (
  input wire logic core_clk, // Clock
  input wire logic we, // Write strobe
  input wire logic [rse_pkg::STK_PTR_W-1:0] waddr, // Write slot
  input wire logic [rse_pkg::PC_W-1:0] wdata, // Write value
  input wire logic [rse_pkg::STK_PTR_W-1:0] raddr, // Read slot
  output logic [rse_pkg::PC_W-1:0] rdata // Registered read value
);
  logic [rse_pkg::PC_W-1:0] mem [rse_pkg::STK_DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
  end
endmodule // rse_stack_mem

// ==== tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_high_level = 1'b0;
  logic latch_we = 1'b0;
  logic [7:0] sh_acc = 8'h00;
  logic [7:0] sh_st = 8'h00;
  logic [7:0] sh_bs = 8'h00;
  logic [7:0] lat_h = 8'h00;
  logic [7:0] lat_u = 8'h00;
  logic [15:0] instr_word;
  logic instr_valid;
  logic instr_ready;
  logic [rse_pkg::PC_W-1:0] pc_out;
  logic [rse_pkg::PC_W-1:0] top;
  logic [rse_pkg::PC_W-1:0] base;
  logic [rse_pkg::STK_PTR_W:0] level;
  logic [7:0] acc, st, bs, lh, lu;
  logic gh, gl, clr_pulse;
  logic clr_seen = 1'b0;
  int errors = 0;
  int compares = 0;
  logic [10:0] offs [3] = '{11'h400, 11'h3FF, 11'h001};

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (!rst_n) clr_seen <= 1'b0;
    else if (clr_pulse === 1'b1) clr_seen <= 1'b1;
  end

  rse_exec u_dut (.core_clk(core_clk), .rst_n(rst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .irq_high_level(irq_high_level), .shadow_accumulator(sh_acc),
    .shadow_status(sh_st), .shadow_bank_select(sh_bs), .pc_latch_high_byte(lat_h),
    .pc_latch_upper_byte(lat_u), .latch_we(latch_we), .instr_ready(instr_ready),
    .pc_out(pc_out), .stack_top_entry(top), .stack_level(level), .accumulator(acc),
    .status_out(st), .bank_select_register(bs), .latch_high_out(lh), .latch_upper_out(lu),
    .high_priority_global_irq_enable(gh), .low_priority_global_irq_enable(gl),
    .master_clear_reset(clr_pulse));
  rse_fetch_model u_mem (.core_clk(core_clk), .rst_n(rst_n), .instr_ready(instr_ready),
    .instr_word(instr_word), .instr_valid(instr_valid));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic gap(input int k, input int cyc);
    chk(21'(u_mem.take_t[k+1] - u_mem.take_t[k]), 21'(20 * cyc));
  endtask
  task automatic shadows(input logic [7:0] a, input logic [7:0] s, input logic [7:0] b);
    sh_acc = a;
    sh_st = s;
    sh_bs = b;
  endtask
  task automatic boot(input logic [15:0] w [8]);
    @(posedge core_clk) #1;
    rst_n = 1'b0;
    for (int i = 0; i < 16; i++) u_mem.prog[i] = (i < 8) ? w[i] : 16'h0000;
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
  endtask
  // Waits for the n-th fetch; effects of all earlier words are then in
  task automatic take(input int n);
    int k;
    k = 0;
    while (u_mem.taken < n && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    #1;
    if (k >= 400) begin
      errors++;
      $display("BAD t=%0t fetch stalled", $time);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_push_pop;
    boot('{16'h0000, rse_pkg::OP_PUSH, rse_pkg::OP_PUSH, 16'hF3C5, rse_pkg::OP_POP, 0, 0, 0});
    take(2);
    base = pc_out;
    take(3);
    chk(top, base + 21'h2);
    chk(pc_out, base + 21'h2);
    take(4);
    chk(top, base + 21'h4);
    chk(21'(level), 21'h2);
    gap(2, 4);
    take(5);
    chk(top, base + 21'h4);
    chk(pc_out, base + 21'h6);
    chk(21'(acc), 21'h0);
    take(6);
    chk(top, base + 21'h2);
    chk(21'(level), 21'h1);
    gap(4, 4);
  endtask
  task automatic t_relcall;
    for (int i = 0; i < 3; i++) begin
      boot('{16'h0000, {rse_pkg::OP_RELCALL_HI, offs[i]}, 0, 0, 0, 0, 0, 0});
      take(2);
      base = pc_out;
      take(3);
      chk(top, base + 21'h2);
      chk(pc_out, base + 21'h2 + {{9{offs[i][10]}}, offs[i], 1'b0});
      gap(1, 8);
    end
  endtask
  task automatic t_litret;
    boot('{16'h0000, 16'hD864, {rse_pkg::OP_LITRET_HI, 8'hA5}, 0, 0, 0, 0, 0});
    take(2);
    base = pc_out;
    lat_h = 8'h3C;
    lat_u = 8'h05;
    latch_we = 1'b1;
    @(posedge core_clk) #1 latch_we = 1'b0;
    take(4);
    chk(pc_out, base + 21'h2);
    chk(21'(level), 21'h0);
    chk(21'(acc), 21'hA5);
    chk({5'h00, lh, lu}, 21'h3C05);
    gap(2, 8);
  endtask
  task automatic t_irqret;
    logic s;
    for (int i = 0; i < 4; i++) begin
      s = i[0];
      irq_high_level = ~s;
      shadows(8'h50 + 8'(i), 8'h61, 8'h0A);
      boot('{16'h0000, 16'hD808, {(i < 2) ? rse_pkg::OP_IRET_HI : rse_pkg::OP_RET_HI, s},
        0, 0, 0, 0, 0});
      take(2);
      base = pc_out;
      take(4);
      chk(pc_out, base + 21'h2);
      chk(21'(level), 21'h0);
      gap(2, 8);
      chk(21'(acc), s ? 21'(sh_acc) : 21'h0);
      chk(21'({st, bs}), s ? 21'({sh_st, sh_bs}) : 21'h0);
      chk(21'({gh, gl}), (i < 2) ? (s ? 21'h1 : 21'h2) : 21'h0);
    end
  endtask
  task automatic t_swreset;
    irq_high_level = 1'b1;
    shadows(8'h77, 8'h11, 8'h02);
    boot('{16'h0000, 16'hD808, 16'h0011, rse_pkg::OP_PUSH, rse_pkg::OP_SWRESET, 0, 0, 0});
    take(5);
    chk(21'({acc, gh, level}), 21'({8'h77, 1'b1, 4'h1}));
    take(6);
    chk(21'(clr_seen), 21'h1);
    chk(21'(acc), 21'h0);
    chk(21'({st, bs, gh, gl}), 21'h0);
    chk(21'(level), 21'h0);
    chk(pc_out, rse_pkg::PC_RESET);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    t_push_pop();
    t_relcall();
    t_litret();
    t_irqret();
    t_swreset();
    results();
  end
  initial begin
    #200000;
    errors++;
    $display("BAD t=%0t watchdog expired", $time);
    results();
  end
endmodule // tb_top
